// [hw/dac_serial_load_rx_config.sv]
`timescale 1ns/1ps
module dac_serial_load_rx_config
	import dac_serial_pkg::*;
(
	// system
	input  wire logic                      clk_sys,
	input  wire logic                      srst,
	// serial port
	input  wire logic                      sclk,
	input  wire logic                      cs_n,
	input  wire logic                      sdi,
	input  wire logic                      dac_mode_pin,
	output logic                           sdo_out,
	output logic                           sdo_oe_n,
	// dac
	output logic [9:0]                     dac_sample,
	output logic                           dac_path_sel,
	// analog control
	output logic [5:0]                     block_enable,
	output dac_serial_pkg::gain_code_t     rx_first_gain_stage,
	output dac_serial_pkg::gain_code_t     rx_second_gain_stage,
	output logic                           filter_band_select
);
	import dac_serial_pkg::*;

	spi_link_if lk ();

	spi_link_shift u_link
	(
		.sclk         (sclk),
		.cs_n         (cs_n),
		.sdi          (sdi),
		.dac_mode_pin (dac_mode_pin),
		.sdo_out      (sdo_out),
		.sdo_oe_n     (sdo_oe_n),
		.lk           (lk.link)
	);

	// synchronisers: first stage feeds only the second
	logic [1:0] tgl_sync_q, tgl_sync_d;
	logic [1:0] cs_sync_q,  cs_sync_d;
	logic       tgl_seen_q, tgl_seen_d;
	logic       cs_prev_q,  cs_prev_d;
	logic [7:0] enable1_q,  enable1_d;
	logic [7:0] gain_q,     gain_d;
	logic [7:0] freq_q,     freq_d;
	logic [9:0] pend_q,     pend_d;
	logic       pend_vld_q, pend_vld_d;
	logic       link_clr_q, link_clr_d;
	logic [9:0] dac_q,      dac_d;
	logic       new_word;
	logic       cs_rise;
	logic [5:0] waddr;

	assign new_word = tgl_sync_q[1] != tgl_seen_q;
	assign cs_rise  = cs_sync_q[1] && !cs_prev_q;
	assign waddr    = lk.word[ADDR_LSB_POS +: ADDR_BITS];

	always_comb
	begin
		tgl_sync_d = {tgl_sync_q[0], lk.word_tgl};
		cs_sync_d  = {cs_sync_q[0], cs_n};
		tgl_seen_d = tgl_sync_q[1];
		cs_prev_d  = cs_sync_q[1];
		enable1_d  = enable1_q;
		gain_d     = gain_q;
		freq_d     = freq_q;
		pend_d     = pend_q;
		pend_vld_d = pend_vld_q;
		link_clr_d = 1'b0;
		dac_d      = dac_q;
		// word is held in the link until the next frame ends, so it is stable here
		if (new_word && lk.word_dac)
		begin
			pend_d     = lk.word[FRAME_BITS - 1 -: DAC_BITS];
			pend_vld_d = 1'b1;
		end
		else if (new_word && !lk.word[RW_POS])
		begin
			if (waddr == ADDR_ENABLE1)
				enable1_d = {2'b00, lk.word[EN_USED_BITS - 1:0]};
			else if (waddr == ADDR_GAIN_SEL)
				gain_d = lk.word[7:0];
			else if (waddr == ADDR_FREQ_CTL)
				freq_d = lk.word[7:0];
		end
		// a word landing in the same cycle as the rise is still delivered
		if (cs_rise && (pend_vld_d))
		begin
			dac_d      = pend_d;
			pend_vld_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			tgl_sync_q <= '0;
			cs_sync_q  <= 2'b11;
			tgl_seen_q <= 1'b0;
			cs_prev_q  <= 1'b1;
			enable1_q  <= RST_ENABLE1;
			gain_q     <= RST_GAIN_SEL;
			freq_q     <= RST_FREQ_CTL;
			pend_q     <= RST_DAC;
			pend_vld_q <= 1'b0;
			link_clr_q <= 1'b1;
			dac_q      <= RST_DAC;
		end
		else
		begin
			tgl_sync_q <= tgl_sync_d;
			cs_sync_q  <= cs_sync_d;
			tgl_seen_q <= tgl_seen_d;
			cs_prev_q  <= cs_prev_d;
			enable1_q  <= enable1_d;
			gain_q     <= gain_d;
			freq_q     <= freq_d;
			pend_q     <= pend_d;
			pend_vld_q <= pend_vld_d;
			link_clr_q <= link_clr_d;
			dac_q      <= dac_d;
		end
	end

	assign lk.rd_enable1  = enable1_q;
	assign lk.rd_gain_sel = gain_q;
	assign lk.rd_freq_ctl = freq_q;
	// registered so the link's asynchronous clear never sees a glitch
	assign lk.link_clr    = link_clr_q;

	assign dac_sample           = dac_q;
	assign dac_path_sel         = enable1_q[EN_DAC_POS];
	assign block_enable         = enable1_q[EN_USED_BITS - 1:0];
	assign rx_first_gain_stage  = gain_q[RX1_GAIN_POS +: 2];
	assign rx_second_gain_stage = gain_q[RX2_GAIN_POS +: 2];
	assign filter_band_select   = freq_q[BAND_POS];
endmodule : dac_serial_load_rx_config

// [hw/dac_serial_pkg.sv]
package dac_serial_pkg;
	localparam int unsigned FRAME_BITS    = 16;
	localparam int unsigned DAC_BITS      = 10;
	localparam int unsigned DAC_LSB_POS   = 6;
	localparam int unsigned RW_POS        = 15;
	localparam int unsigned ADDR_BITS     = 6;
	localparam int unsigned ADDR_LSB_POS  = 8;
	localparam int unsigned HDR_BITS      = 8;

	localparam logic [5:0] ADDR_ENABLE1   = 6'h01;
	localparam logic [5:0] ADDR_GAIN_SEL  = 6'h02;
	localparam logic [5:0] ADDR_FREQ_CTL  = 6'h04;

	localparam logic [7:0] RST_ENABLE1    = 8'h00;
	localparam logic [7:0] RST_GAIN_SEL   = 8'h32;
	localparam logic [7:0] RST_FREQ_CTL   = 8'h00;
	localparam logic [9:0] RST_DAC        = 10'h000;

	localparam int unsigned EN_DAC_POS    = 5;
	localparam int unsigned EN_USED_BITS  = 6;
	localparam int unsigned RX1_GAIN_POS  = 0;
	localparam int unsigned RX2_GAIN_POS  = 4;
	localparam int unsigned BAND_POS      = 3;

	// gain codes: rx1 0=0.25 1=0.5 2=1 3=2 V/V; rx2 0=1 1=4 2=16 3=64 V/V
	typedef logic [1:0] gain_code_t;
endpackage : dac_serial_pkg

// [hw/spi_link_if.sv]
`timescale 1ns/1ps
interface spi_link_if;
	logic [15:0] word;
	logic        word_dac;
	logic        word_tgl;
	logic        link_clr;
	logic [7:0]  rd_enable1;
	logic [7:0]  rd_gain_sel;
	logic [7:0]  rd_freq_ctl;

	modport link
	(
		output word, word_dac, word_tgl,
		input  rd_enable1, rd_gain_sel, rd_freq_ctl, link_clr
	);
	modport core
	(
		input  word, word_dac, word_tgl,
		output rd_enable1, rd_gain_sel, rd_freq_ctl, link_clr
	);
endinterface : spi_link_if

// [hw/spi_link_shift.sv]
`timescale 1ns/1ps
module spi_link_shift
	import dac_serial_pkg::*;
(
	// serial pins
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic sdi,
	input  wire logic dac_mode_pin,
	output logic      sdo_out,
	output logic      sdo_oe_n,
	// core side
	spi_link_if.link  lk
);
	import dac_serial_pkg::*;

	// chip select high clears the frame; sclk is idle then, so it is the only way
	logic [4:0]  cnt_q,   cnt_d;
	logic [15:0] shift_q, shift_d;
	logic [7:0]  hdr_q,   hdr_d;
	logic [15:0] word_q,  word_d;
	logic        dac_q,   dac_d;
	logic        tgl_q,   tgl_d;
	logic [1:0]  mode_q,  mode_d;
	logic        sdo_q,   sdo_d;
	logic        oen_q,   oen_d;
	logic [7:0]  rd_byte;
	logic [15:0] shifted;

	assign shifted = {shift_q[14:0], sdi};

	always_comb
	begin
		cnt_d   = cnt_q;
		shift_d = shifted;
		hdr_d   = hdr_q;
		word_d  = word_q;
		dac_d   = dac_q;
		tgl_d   = tgl_q;
		mode_d  = {mode_q[0], dac_mode_pin};
		if (cnt_q != 5'(FRAME_BITS))
			cnt_d = cnt_q + 5'd1;
		if (cnt_q == 5'(HDR_BITS - 1))
			hdr_d = shifted[7:0];
		if (cnt_q == 5'(FRAME_BITS - 1))
		begin
			word_d = shifted;
			dac_d  = mode_q[1];
			tgl_d  = ~tgl_q;
		end
	end

	always_ff @(posedge sclk or posedge cs_n)
	begin
		if (cs_n)
		begin
			cnt_q   <= '0;
			shift_q <= '0;
			hdr_q   <= '0;
			mode_q  <= '0;
		end
		else
		begin
			cnt_q   <= cnt_d;
			shift_q <= shift_d;
			hdr_q   <= hdr_d;
			mode_q  <= mode_d;
		end
	end

	// word and toggle survive chip select so the core can still collect them
	always_ff @(posedge sclk)
	begin
		word_q <= word_d;
		dac_q  <= dac_d;
	end

	// toggle must start known or no word ever reaches the core; sclk idles in reset
	always_ff @(posedge sclk or posedge lk.link_clr)
	begin
		if (lk.link_clr)
			tgl_q <= 1'b0;
		else
			tgl_q <= tgl_d;
	end

	// readback registers are static while a frame runs, so sampled directly
	always_comb
	begin
		rd_byte = 8'h00;
		if (hdr_q[5:0] == ADDR_ENABLE1)
			rd_byte = lk.rd_enable1;
		else if (hdr_q[5:0] == ADDR_GAIN_SEL)
			rd_byte = lk.rd_gain_sel;
		else if (hdr_q[5:0] == ADDR_FREQ_CTL)
			rd_byte = lk.rd_freq_ctl;
	end

	always_comb
	begin
		sdo_d = 1'b0;
		oen_d = 1'b1;
		if (hdr_q[7] && !mode_q[1] && cnt_q >= 5'(HDR_BITS) && cnt_q < 5'(FRAME_BITS))
		begin
			sdo_d = rd_byte[3'(5'(FRAME_BITS - 1) - cnt_q)];
			oen_d = 1'b0;
		end
	end

	// read data moves on the falling edge
	always_ff @(negedge sclk or posedge cs_n)
	begin
		if (cs_n)
		begin
			sdo_q <= 1'b0;
			oen_q <= 1'b1;
		end
		else
		begin
			sdo_q <= sdo_d;
			oen_q <= oen_d;
		end
	end

	assign sdo_out     = sdo_q;
	assign sdo_oe_n    = oen_q;
	assign lk.word     = word_q;
	assign lk.word_dac = dac_q;
	assign lk.word_tgl = tgl_q;
endmodule : spi_link_shift

// [verif/dac_serial_load_rx_config_assertions.sv]
`timescale 1ns/1ps
module dac_serial_chk
	import dac_serial_pkg::*;
(
	// system
	input wire logic	clk_sys,
	input wire logic	srst,
	// serial port
	input wire logic	sclk,
	input wire logic	cs_n,
	input wire logic	sdi,
	input wire logic	dac_mode_pin,
	input wire logic	sdo_out,
	input wire logic	sdo_oe_n,
	// outputs
	input wire logic [9:0]	dac_sample,
	input wire logic	dac_path_sel,
	input wire logic [5:0]	block_enable,
	input wire dac_serial_pkg::gain_code_t	rx_first_gain_stage,
	input wire dac_serial_pkg::gain_code_t	rx_second_gain_stage,
	input wire logic	filter_band_select
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	sequence cs_quiet;
		cs_n [*2];
	endsequence
	sequence mode_held;
		dac_mode_pin [*2];
	endsequence
	chk_rst_dac: assert property (disable iff (1'b0) srst |=> dac_sample == 10'h000)
		else $error("dac sample not cleared by reset");
	chk_rst_gain: assert property (disable iff (1'b0) srst |=> rx_first_gain_stage == 2'h2
		&& rx_second_gain_stage == 2'h3 && !filter_band_select)
		else $error("gain or band reset value wrong");
	chk_dac_on_cs: assert property ($changed(dac_sample) |-> $past(cs_n, 2))
		else $error("dac sample moved while chip select low");
	chk_oe_idle: assert property (cs_quiet |-> sdo_oe_n)
		else $error("sdo driven with chip select high");
	chk_dac_nodrive: assert property (mode_held |-> sdo_oe_n)
		else $error("sdo driven in dac mode");
	chk_path_bit: assert property (dac_path_sel == block_enable[5])
		else $error("dac path select differs from enable bit");
	chk_sdo_quiet: assert property (sdo_oe_n |-> !sdo_out)
		else $error("sdo not low while released");
	chk_cfg_kept: assert property ($changed({rx_first_gain_stage, rx_second_gain_stage,
		filter_band_select, block_enable}) |-> !$past(dac_mode_pin, 4))
		else $error("config changed by a dac mode word");
endmodule : dac_serial_chk

bind dac_serial_load_rx_config dac_serial_chk u_chk (.clk_sys, .srst, .sclk, .cs_n, .sdi,
	.dac_mode_pin, .sdo_out, .sdo_oe_n, .dac_sample, .dac_path_sel, .block_enable,
	.rx_first_gain_stage, .rx_second_gain_stage, .filter_band_select);

// [verif/spi_host_model.sv]
`timescale 1ns/1ps
module spi_host_model
(
	// serial pins
	output logic		sclk,
	output logic		cs_n,
	output logic		sdi,
	output logic		dac_mode_pin,
	// readback
	input wire logic	sdo_out,
	input wire logic	sdo_oe_n
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		dac_mode_pin = 1'b0;
	end
	// sclk stands low outside frames; undriven sdo reads as x
	task automatic xfer(input logic m, input logic [15:0] w, output logic [7:0] rd);
		rd = 8'h00;
		cs_n = 1'b0;
		#6 dac_mode_pin = m;
		for (int i = 15; i >= 0; i--)
		begin
			#6 sclk = 1'b0;
			sdi = w[i];
			#6 sclk = 1'b1;
			if (i < 8)
				rd[i] = sdo_oe_n ? 1'bx : sdo_out;
		end
		#6 sclk = 1'b0;
		#6 cs_n = 1'b1;
		dac_mode_pin = 1'b0;
		sdi = ~sdi;
		#60;
	endtask : xfer
endmodule : spi_host_model

// [verif/test_dac_serial_load_rx_config.sv]
`timescale 1ns/1ps
module test_dac_serial_load_rx_config;
	import dac_serial_pkg::*;
	logic		clk_sys, srst, sclk, cs_n, sdi, dac_mode_pin, sdo_out, sdo_oe_n;
	logic		dac_path_sel, band;
	logic [9:0]	dac_sample, dac_e;
	logic [5:0]	block_enable;
	gain_code_t	g1, g2;
	logic [7:0]	en_e, gs_e, fc_e, rd;
	logic [15:0]	w;
	int		fail_count, checked;

	spi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .dac_mode_pin(dac_mode_pin),
		.sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n));
	dac_serial_load_rx_config u_dut (.clk_sys(clk_sys), .srst(srst), .sclk(sclk),
		.cs_n(cs_n), .sdi(sdi), .dac_mode_pin(dac_mode_pin), .sdo_out(sdo_out),
		.sdo_oe_n(sdo_oe_n), .dac_sample(dac_sample), .dac_path_sel(dac_path_sel),
		.block_enable(block_enable), .rx_first_gain_stage(g1), .rx_second_gain_stage(g2),
		.filter_band_select(band));

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task chk(input string n, input logic [21:0] e, input logic [21:0] g);
		checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task cmp_out();
		chk("outputs", {dac_e, en_e[5:0], en_e[5], gs_e[1:0], gs_e[5:4], fc_e[3]},
			{dac_sample, block_enable, dac_path_sel, g1, g2, band});
	endtask : cmp_out
	// bench model of the register file and the held sample
	task automatic op(input logic m, input logic [15:0] v);
		@(posedge clk_sys);
		#1;
		u_host.xfer(m, v, rd);
		if (m)
			dac_e = v[15:6];
		else if (!v[15])
			case (v[13:8])
				6'h01: en_e = v[7:0] & 8'h3f;
				6'h02: gs_e = v[7:0];
				6'h04: fc_e = v[7:0];
				default: ;
			endcase
		cmp_out();
	endtask : op
	task end_sim();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	initial
	begin
		#200000;
		fail_count++;
		end_sim();
	end
	initial
	begin
		srst = 1'b1;
		fail_count = 0;
		checked = 0;
		dac_e = 10'h000;
		en_e = 8'h00;
		gs_e = 8'h32;
		fc_e = 8'h00;
		void'($urandom(32));
		repeat (8) @(posedge clk_sys);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1 cmp_out();
		$display("test reset done");
		for (int g = 0; g < 16; g++)
			op(1'b0, {8'h02, 2'h0, g[3:2], 2'h0, g[1:0]});
		op(1'b0, 16'h0408);
		op(1'b0, 16'h0400);
		$display("test gain band done");
		w = 16'($urandom());
		op(1'b0, {8'h01, w[7:0]});
		op(1'b0, 16'h8100);
		chk("read enable", {14'h0000, en_e}, {14'h0000, rd});
		op(1'b0, 16'hbf55);
		chk("read unmapped", {14'h0000, 8'h00}, {14'h0000, rd});
		$display("test register done");
		op(1'b1, 16'h003f);
		op(1'b1, 16'hffc0);
		repeat (4)
		begin
			w = 16'($urandom());
			op(1'b1, w);
		end
		op(1'b0, {8'h01, ~w[7:0]});
		$display("test dac done");
		end_sim();
	end
endmodule : test_dac_serial_load_rx_config
